/* design/tws_slave.sv */
`timescale 1ns/10ps
// Operation
// - Data line is bidirectional, driven only for acknowledge and read data.
// - Bits move on the master-driven serial clock.
// - Respond only when upper six address bits equal 001000.
// - Address low bit must match the address-select pin level.
// - Eighth address bit: one reads, zero writes.
// - First byte after a write address loads the pointer.
// - Following write bytes store into the pointed register.
// - Read returns the pointed register right after the address byte.
// - Auto-increment off keeps the pointer fixed across bytes.
// - Auto-increment on advances the pointer after each byte.
// - Auto-increment is pointer-byte bit 7, reset zero; bits 6..3 reserved.
// - Pointer is bits 2..0, resets to 000.
// - A falling edge on address-select selects 4-wire mode permanently.
// - Port runs independent of audio clocks, no audio-clock sync.
module tws_slave
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // Two-wire pins
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  input  wire logic                   address_select_pin,
  // Register file view
  output logic [TWS_REG_COUNT*8-1:0]  reg_file,
  output logic                        four_wire_mode
);
  // Two-flop synchronisers; stage one feeds only stage two
  logic [1:0] scl_s_q, sda_s_q, ads_s_q;
  logic       scl_d1_q, sda_d1_q, ads_d1_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_s_q  <= 2'h3;
      sda_s_q  <= 2'h3;
      ads_s_q  <= 2'h0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      ads_d1_q <= 1'b0;
    end else begin
      scl_s_q  <= {scl_s_q[0], scl_in};
      sda_s_q  <= {sda_s_q[0], sda_in};
      ads_s_q  <= {ads_s_q[0], address_select_pin};
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
      ads_d1_q <= ads_s_q[1];
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl      = scl_s_q[1];
  assign sda      = sda_s_q[1];
  assign scl_rise = scl & ~scl_d1_q;
  assign scl_fall = ~scl & scl_d1_q;
  assign start_c  = scl & scl_d1_q & sda_d1_q & ~sda;
  assign stop_c   = scl & scl_d1_q & ~sda_d1_q & sda;

  // Falling edge only counts once the reset-time level is seen high
  logic mode_q, ads_seen_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_q     <= 1'b0;
      ads_seen_q <= 1'b0;
    end else begin
      ads_seen_q <= 1'b1;
      if (ads_seen_q && ads_d1_q && !ads_s_q[1])
        mode_q <= 1'b1;
    end
  end
  assign four_wire_mode = mode_q;

  tws_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] regs_q [TWS_REG_COUNT];
  logic       drive_q, out_q, ack_ok_q, master_ack_q, armed_q;

  function automatic logic [2:0] next_ptr(input logic [7:0] p);
    next_ptr = p[TWS_AUTO_INCREMENT_ENABLE_BIT] ? p[TWS_PTR_MSB:0] + 3'h1 : p[TWS_PTR_MSB:0];
  endfunction

  logic addr_hit;
  assign addr_hit = (shift_q[7:2] == TWS_ADDR_UPPER)
                  && (shift_q[1] == ads_d1_q);

  // Byte engine; sampling on SCL rise, driving on SCL fall
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q      <= TWS_IDLE;
      bit_q        <= 4'h0;
      shift_q      <= 8'h00;
      ptr_q        <= TWS_PTR_RESET;
      drive_q      <= 1'b0;
      out_q        <= 1'b1;
      ack_ok_q     <= 1'b0;
      master_ack_q <= 1'b0;
      armed_q      <= 1'b0;
      for (int i = 0; i < TWS_REG_COUNT; i++) regs_q[i] <= 8'h00;
    end else if (mode_q) begin
      state_q <= TWS_IDLE;
      drive_q <= 1'b0;
    end else if (start_c) begin
      state_q <= TWS_ADDR;
      bit_q   <= 4'h0;
      drive_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= TWS_IDLE;
      drive_q <= 1'b0;
    end else if (state_q != TWS_IDLE && state_q != TWS_SKIP) begin
      if (scl_rise) begin
        armed_q <= 1'b1;
        if (bit_q == TWS_BIT_ACK) begin
          master_ack_q <= ~sda;
        end else if (state_q != TWS_RDAT) begin
          // Read bits shift on the fall only
          shift_q <= {shift_q[6:0], sda};
        end
      end
      // The fall that closes a START is not a bit
      if (scl_fall && armed_q) begin
        if (bit_q == TWS_BIT_LAST) begin
          bit_q <= TWS_BIT_ACK;
          case (state_q)
            TWS_ADDR: begin
              ack_ok_q <= addr_hit;
              drive_q  <= addr_hit;
              out_q    <= 1'b0;
            end
            TWS_PTR: begin
              ptr_q   <= shift_q & 8'h87;
              drive_q <= 1'b1;
              out_q   <= 1'b0;
            end
            TWS_WDAT: begin
              regs_q[ptr_q[TWS_PTR_MSB:0]] <= shift_q;
              ptr_q[TWS_PTR_MSB:0] <= next_ptr(ptr_q);
              drive_q <= 1'b1;
              out_q   <= 1'b0;
            end
            TWS_RDAT: begin
              drive_q <= 1'b0;
              ptr_q[TWS_PTR_MSB:0] <= next_ptr(ptr_q);
            end
            default: drive_q <= 1'b0;
          endcase
        end else if (bit_q == TWS_BIT_ACK) begin
          bit_q <= 4'h0;
          case (state_q)
            TWS_ADDR: begin
              if (!ack_ok_q) begin
                state_q <= TWS_SKIP;
                drive_q <= 1'b0;
              end else if (shift_q[0]) begin
                state_q <= TWS_RDAT;
                drive_q <= ~regs_q[ptr_q[TWS_PTR_MSB:0]][7];
                out_q   <= 1'b0;
                shift_q <= {regs_q[ptr_q[TWS_PTR_MSB:0]][6:0], 1'b0};
              end else begin
                state_q <= TWS_PTR;
                drive_q <= 1'b0;
              end
            end
            TWS_PTR: begin
              state_q <= TWS_WDAT;
              drive_q <= 1'b0;
            end
            TWS_RDAT: begin
              if (master_ack_q) begin
                drive_q <= ~regs_q[ptr_q[TWS_PTR_MSB:0]][7];
                out_q   <= 1'b0;
                shift_q <= {regs_q[ptr_q[TWS_PTR_MSB:0]][6:0], 1'b0};
              end else begin
                state_q <= TWS_SKIP;
                drive_q <= 1'b0;
              end
            end
            default: drive_q <= 1'b0;
          endcase
        end else begin
          bit_q <= bit_q + 4'h1;
          if (state_q == TWS_RDAT) begin
            // Open drain: only a zero pulls the line
            drive_q <= ~shift_q[7];
            shift_q <= {shift_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  assign sda_out = out_q;
  assign sda_oe  = drive_q;

  always_comb begin
    for (int i = 0; i < TWS_REG_COUNT; i++) reg_file[i*8 +: 8] = regs_q[i];
  end

  // Audio clocks never appear: whole port lives on sys_clk

  a_mismatch_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_q == TWS_SKIP) |-> !sda_oe)
    else $error("data line driven after address mismatch");

  a_reset_ptr: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> ptr_q == 8'h00)
    else $error("pointer not reset to zero");

  a_ptr_resv: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ptr_q[6:3] == 4'h0)
    else $error("reserved pointer bits kept");

  a_hold_ptr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_q == TWS_WDAT && !ptr_q[7]) |=> $stable(ptr_q[2:0]) || start_c || $past(start_c))
    else $error("pointer moved without auto-increment");

  a_mode_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
    four_wire_mode |=> four_wire_mode)
    else $error("four-wire mode lost");

  a_mode_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    four_wire_mode |=> !sda_oe)
    else $error("two-wire port active in four-wire mode");

  a_ack_hit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_q == TWS_ADDR && bit_q == TWS_BIT_ACK && sda_oe) |-> ack_ok_q)
    else $error("acknowledged a foreign address");

  a_stop_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (stop_c && !mode_q) |=> !sda_oe && state_q == TWS_IDLE)
    else $error("line not released at stop");
endmodule // tws_slave

/* design/tws_pkg.sv */
package tws_pkg;
  localparam logic [5:0] TWS_ADDR_UPPER  = 6'h08;
  localparam int         TWS_AUTO_INCREMENT_ENABLE_BIT    = 7;
  localparam int         TWS_PTR_MSB     = 2;
  localparam logic [7:0] TWS_PTR_RESET   = 8'h00;
  localparam int         TWS_REG_COUNT   = 8;
  localparam int         TWS_BITS_BYTE   = 8;
  localparam logic [3:0] TWS_BIT_LAST    = 4'h7;
  localparam logic [3:0] TWS_BIT_ACK     = 4'h8;

  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_PTR  = 3'b011,
    TWS_WDAT = 3'b010,
    TWS_RDAT = 3'b110,
    TWS_SKIP = 3'b111
  } tws_state_t;
endpackage

/* verification/tws_host.sv */
`timescale 1ns/10ps
// Bus master; clock rests high between frames
module tws_host (
  // Clock
  input  wire logic sys_clk,
  // Bus
  input  wire logic sda_line,
  output logic      scl_line,
  output logic      host_oe
);
  initial begin
    scl_line = 1'b1;
    host_oe  = 1'b0;
  end
  task automatic qtr;
    repeat (8) @(negedge sys_clk);
  endtask
  // Also serves as repeated start
  task automatic start_c;
    host_oe = 1'b0;
    qtr;
    scl_line = 1'b1;
    qtr;
    host_oe = 1'b1;
    qtr;
    scl_line = 1'b0;
    qtr;
  endtask
  task automatic stop_c;
    host_oe = 1'b1;
    qtr;
    scl_line = 1'b1;
    qtr;
    host_oe = 1'b0;
    qtr;
  endtask
  // Open drain: only ever pulls low
  task automatic bit_x(input logic b, output logic r);
    host_oe = ~b;
    qtr;
    scl_line = 1'b1;
    qtr;
    r = sda_line;
    qtr;
    scl_line = 1'b0;
    qtr;
  endtask
  task automatic byte_x(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                        output logic ar);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ab, ar);
  endtask
endmodule // tws_host

/* verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import tws_pkg::*;
;
  logic                       sys_clk = 1'b0;
  logic                       sys_rst;
  logic                       address_select_pin;
  logic                       sda_out;
  logic                       sda_oe;
  logic                       four_wire_mode;
  logic                       scl_line;
  logic                       host_oe;
  logic [TWS_REG_COUNT*8-1:0] reg_file;
  int                         errors;
  int                         total_checks;
  // Pull-up resolves the shared data wire
  wire logic sda_line = (sda_oe ? sda_out : 1'b1) & ~host_oe;

  always #2.5 sys_clk = ~sys_clk;

  tws_slave dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
    .reg_file(reg_file), .four_wire_mode(four_wire_mode));
  tws_host host (.sys_clk(sys_clk), .sda_line(sda_line), .scl_line(scl_line),
    .host_oe(host_oe));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  // Every byte gets the same expected acknowledge
  task automatic wr(input logic [7:0] a, p, d0, d1, input logic ack);
    logic [31:0] v;
    logic [7:0]  rx;
    logic        ar;
    v = {a, p, d0, d1};
    host.start_c;
    for (int i = 0; i < 4; i++) begin
      host.byte_x(v[31-8*i -: 8], 1'b1, rx, ar);
      chk(ar, ack, "write ack");
    end
    host.stop_c;
  endtask
  task automatic rd(input logic [7:0] a, e0, e1);
    logic [7:0] rx;
    logic       ar;
    host.start_c;
    host.byte_x(a, 1'b1, rx, ar);
    chk(ar, 1'b0, "read ack");
    host.byte_x(8'hff, 1'b0, rx, ar);
    chk(rx, e0, "first read byte");
    host.byte_x(8'hff, 1'b1, rx, ar);
    chk(rx, e1, "second read byte");
    host.stop_c;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    $display("MISMATCH %0t run did not finish", $time);
    results;
  end

  initial begin
    sys_rst = 1'b1;
    address_select_pin = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(reg_file, 64'h0, "reset registers");
    chk({four_wire_mode, sda_oe}, 2'h0, "reset flags");
    $display("test reset done");
    wr(8'h20, 8'h82, 8'h55, 8'haa, 1'b0);
    chk(reg_file[31:16], 16'haa55, "block write");
    wr(8'h20, 8'h7d, 8'h11, 8'h22, 1'b0);
    chk(reg_file[55:40], 16'h0022, "fixed pointer");
    rd(8'h21, 8'h22, 8'h22);
    $display("test write and read done");
    wr(8'h20, 8'h87, 8'h33, 8'h44, 1'b0);
    rd(8'h21, 8'h00, 8'h55);
    wr(8'h30, 8'h80, 8'hee, 8'hee, 1'b1);
    wr(8'h22, 8'h80, 8'hee, 8'hee, 1'b1);
    chk(reg_file, 64'h3300_2200_aa55_0044, "ignored transfers");
    $display("test address match done");
    address_select_pin = 1'b1;
    wr(8'h22, 8'h80, 8'h66, 8'h77, 1'b0);
    chk(reg_file[15:0], 16'h7766, "pin high address");
    address_select_pin = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(four_wire_mode, 1'b1, "mode lock");
    wr(8'h20, 8'h80, 8'h99, 8'h99, 1'b1);
    chk(reg_file, 64'h3300_2200_aa55_7766, "locked mode writes");
    $display("test mode lock done");
    results;
  end
endmodule // tb_top
